/* verilog/uep0_pkg.sv */
// shared constants, types and register map of the endpoint-zero output and status block
package uep0_pkg;

  // ***********************************************************************
  // register map: printed offsets are indices, byte address is index * 4
  // ***********************************************************************
  localparam logic [15:0] IDX_CFG  = 16'hff82;
  localparam logic [15:0] IDX_BCNT = 16'hff83;
  localparam logic [15:0] IDX_MSK  = 16'hfffd;
  localparam logic [15:0] IDX_STA  = 16'hfffe;
  localparam logic [15:0] IDX_FADR = 16'hffff;
  localparam logic [31:0] ADR_CFG  = {14'h0000, IDX_CFG, 2'b00};
  localparam logic [31:0] ADR_BCNT = {14'h0000, IDX_BCNT, 2'b00};
  localparam logic [31:0] ADR_MSK  = {14'h0000, IDX_MSK, 2'b00};
  localparam logic [31:0] ADR_STA  = {14'h0000, IDX_STA, 2'b00};
  localparam logic [31:0] ADR_FADR = {14'h0000, IDX_FADR, 2'b00};

  // ***********************************************************************
  // field positions
  // ***********************************************************************
  localparam int CFG_IE_BIT    = 2;
  localparam int CFG_STALL_BIT = 3;
  localparam int CFG_TOG_BIT   = 5;
  localparam int CFG_BUFFER_MANAGER_ALLOW_BIT  = 7;
  localparam int BCNT_NAK_BIT  = 7;
  localparam int STA_SETUP_OVERWRITE_FLAG_BIT = 0;
  localparam int STA_WAKE_BIT  = 1;
  localparam int STA_SETUP_BIT = 2;
  localparam int STA_RING_BIT  = 3;
  localparam int STA_RES_BIT   = 5;
  localparam int STA_SUS_BIT   = 6;
  localparam int STA_RST_BIT   = 7;

  // ***********************************************************************
  // reset values, masks and limits
  // ***********************************************************************
  localparam logic       CFG_IE_RST    = 1'b0;
  localparam logic       CFG_STALL_RST = 1'b0;
  localparam logic       CFG_TOG_RST   = 1'b0;
  localparam logic       CFG_BUFFER_MANAGER_ALLOW_RST  = 1'b0;
  localparam logic       BCNT_NAK_RST  = 1'b1;
  localparam logic [3:0] BCNT_CNT_RST  = 4'h0;
  localparam logic [6:0] FADR_RST      = 7'h00;
  localparam logic [7:0] STA_RST       = 8'h00;
  localparam logic [7:0] MSK_RST       = 8'h00;
  localparam logic [7:0] STA_IMPL_MASK = 8'hef;
  localparam logic [3:0] BCNT_MAX      = 4'h8;
  localparam logic [3:0] EP_ZERO       = 4'h0;

  // ***********************************************************************
  // bus answers, token kinds, handshakes
  // ***********************************************************************
  localparam logic [1:0] RESP_OKAY   = 2'b00;
  localparam logic [1:0] RESP_DECERR = 2'b11;

  typedef enum logic [2:0] {TOK_SETUP = 3'b001, TOK_OUT = 3'b010, TOK_IN = 3'b100} uep0_tok_kind_t;
  typedef enum logic [2:0] {HS_ACK = 3'b001, HS_NAK = 3'b010, HS_STALL = 3'b100} uep0_hs_code_t;

  typedef struct packed {
    logic        awvalid;
    logic [31:0] awaddr;
    logic        wvalid;
    logic [31:0] wdata;
    logic [3:0]  wstrb;
    logic        bready;
    logic        arvalid;
    logic [31:0] araddr;
    logic        rready;
  } uep0_axil_req_t;

  typedef struct packed {
    logic        awready;
    logic        wready;
    logic        bvalid;
    logic [1:0]  bresp;
    logic        arready;
    logic        rvalid;
    logic [31:0] rdata;
    logic [1:0]  rresp;
  } uep0_axil_rsp_t;

  typedef struct packed {
    logic           valid;
    uep0_tok_kind_t kind;
    logic [6:0]     addr;
    logic [3:0]     ep;
    logic [3:0]     len;
    logic           pid;
  } uep0_tok_t;

  typedef struct packed {
    logic          valid;
    uep0_hs_code_t code;
  } uep0_hs_t;

endpackage : uep0_pkg

/* verilog/uep0_sync.sv */
// three-stage synchroniser with agreement filter for pin inputs
`timescale 1ns/1ps
module uep0_sync
  import uep0_pkg::*;
(
  input  wire logic mclk,
  input  wire logic rst_n,
  input  wire logic pinIn,
  output logic      level
);

  typedef struct packed {
    logic s1;
    logic s2;
    logic s3;
    logic stable;
  } uep0_sync_st_t;

  uep0_sync_st_t s;
  uep0_sync_st_t next_s;

  // s1 feeds only s2; the filter looks at s2 and s3
  always_comb
  begin
    next_s    = s;
    next_s.s1 = pinIn;
    next_s.s2 = s.s1;
    next_s.s3 = s.s2;
    if (s.s2 == s.s3)
    begin
      next_s.stable = s.s3;
    end
  end

  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      s <= '0;
    end
    else
    begin
      s <= next_s;
    end
  end

  assign level = s.stable;

endmodule : uep0_sync

/* verilog/uep0_axil_slave.sv */
// axi4-lite slave front end: holds one write and one read, strobes the register file
`timescale 1ns/1ps
module uep0_axil_slave
  import uep0_pkg::*;
(
  input  wire logic     mclk,
  input  wire logic     rst_n,
  input  uep0_axil_req_t req,
  output uep0_axil_rsp_t rsp,
  output logic          wrEn,
  output logic [31:0]   wrAddr,
  output logic [31:0]   wrData,
  output logic [3:0]    wrStrb,
  input  wire logic     wrHit,
  output logic [31:0]   rdAddr,
  input  wire logic [31:0] rdData,
  input  wire logic     rdHit
);

  typedef struct packed {
    logic           awHeld;
    logic           wHeld;
    logic           arHeld;
    logic [31:0]    awAddr;
    logic [31:0]    wData;
    logic [3:0]     wStrb;
    logic [31:0]    arAddr;
    uep0_axil_rsp_t rsp;
  } uep0_slv_st_t;

  uep0_slv_st_t s;
  uep0_slv_st_t next_s;

  always_comb
  begin
    next_s = s;
    wrEn   = 1'b0;
    if (req.awvalid && s.rsp.awready)
    begin
      next_s.awHeld = 1'b1;
      next_s.awAddr = req.awaddr;
    end
    if (req.wvalid && s.rsp.wready)
    begin
      next_s.wHeld = 1'b1;
      next_s.wData = req.wdata;
      next_s.wStrb = req.wstrb;
    end
    if (s.rsp.bvalid && req.bready)
    begin
      next_s.rsp.bvalid = 1'b0;
    end
    // commit only once both halves are in and the last answer is gone
    if (s.awHeld && s.wHeld && !s.rsp.bvalid)
    begin
      wrEn              = 1'b1;
      next_s.awHeld     = 1'b0;
      next_s.wHeld      = 1'b0;
      next_s.rsp.bvalid = 1'b1;
      next_s.rsp.bresp  = wrHit ? RESP_OKAY : RESP_DECERR;
    end
    if (req.arvalid && s.rsp.arready)
    begin
      next_s.arHeld = 1'b1;
      next_s.arAddr = req.araddr;
    end
    if (s.rsp.rvalid && req.rready)
    begin
      next_s.rsp.rvalid = 1'b0;
    end
    if (s.arHeld && !s.rsp.rvalid)
    begin
      next_s.arHeld     = 1'b0;
      next_s.rsp.rvalid = 1'b1;
      next_s.rsp.rdata  = rdData;
      next_s.rsp.rresp  = rdHit ? RESP_OKAY : RESP_DECERR;
    end
    next_s.rsp.awready = !next_s.awHeld && !next_s.rsp.bvalid;
    next_s.rsp.wready  = !next_s.wHeld && !next_s.rsp.bvalid;
    next_s.rsp.arready = !next_s.arHeld && !next_s.rsp.rvalid;
  end

  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      s <= '0;
    end
    else
    begin
      s <= next_s;
    end
  end

  assign rsp    = s.rsp;
  assign wrAddr = s.awAddr;
  assign wrData = s.wData;
  assign wrStrb = s.wStrb;
  assign rdAddr = s.arAddr;

endmodule : uep0_axil_slave

/* verilog/uep0_out_status.sv */
// endpoint-zero output control, function address and usb event status registers
//
// Functional notes
// - config bit 2 enables completion interrupt
// - stall bit answers STALL, then self-clears
// - config bit 5 mirrors data toggle
// - config bit 7 allows buffer manager
// - byte count holds zero to eight
// - count nak bit zero accepts next OUT
// - count nak bit one NAKs OUT; resets one
// - seven-bit function address, reset zero
// - status flags hardware-set, write-one-clear
// - set flag with enable raises interrupt
// - status bit 0 flags setup overwrite
// - status bit 1 flags remote wakeup input
// - status bit 2 setup; NAKs endpoint zero
// - status bit 3 ring indicate rising edge
// - status bit 5 flags bus resume
// - status bit 6 flags bus suspend
// - status bit 7 port reset, survives function reset
// - mask register enables each status flag
//
// Local design decision: the AXI4-Lite register port.
`timescale 1ns/1ps
module uep0_out_status
  import uep0_pkg::*;
(
  input  wire logic      mclk,
  input  wire logic      rst_n,
  input  uep0_axil_req_t axiReq,
  output uep0_axil_rsp_t axiRsp,
  input  uep0_tok_t      tok,
  output uep0_hs_t       hs,
  input  wire logic      portResetPulse,
  input  wire logic      suspendPulse,
  input  wire logic      resumePulse,
  input  wire logic      wakeupPin,
  input  wire logic      ringPin,
  output logic           bufMgrAllow,
  output logic           ep0OutDone,
  output logic           usbIrq
);

  // ***********************************************************************
  // helpers
  // ***********************************************************************

  // reserved codes never reach the count field
  function automatic logic [3:0] clampCount(input logic [3:0] raw);
    clampCount = (raw > BCNT_MAX) ? BCNT_MAX : raw;
  endfunction : clampCount

  function automatic logic isMapped(input logic [31:0] adr);
    isMapped = (adr == ADR_CFG) ||
               (adr == ADR_BCNT) ||
               (adr == ADR_MSK) ||
               (adr == ADR_STA) ||
               (adr == ADR_FADR);
  endfunction : isMapped

  // edge of the filtered level; a raw pin could glitch a second event
  function automatic logic roseNow(input logic now, input logic prev);
    roseNow = now && !prev;
  endfunction : roseNow

  // ***********************************************************************
  // state
  // ***********************************************************************
  typedef struct packed {
    logic       cfgUbme;
    logic       cfgStall;
    logic       cfgIe;
    logic       toggle;
    logic       bcntNak;
    logic [3:0] bcntCnt;
    logic [6:0] fadr;
    logic [7:0] sta;
    logic [7:0] msk;
    logic       wakePrev;
    logic       ringPrev;
    uep0_hs_t   hs;
    logic       done;
    logic       irq;
    logic       allow;
  } uep0_main_st_t;

  uep0_main_st_t s;
  uep0_main_st_t next_s;

  logic        wrEn;
  logic [31:0] wrAddr;
  logic [31:0] wrData;
  logic [3:0]  wrStrb;
  logic [31:0] rdAddr;
  logic [31:0] rdData;
  logic        wakeLevel;
  logic        ringLevel;
  logic [7:0]  evt;
  logic        forUs;

  // ***********************************************************************
  // bus front end and pin synchronisers
  // ***********************************************************************
  uep0_axil_slave u_slave
  (
    .mclk   (mclk),
    .rst_n  (rst_n),
    .req    (axiReq),
    .rsp    (axiRsp),
    .wrEn   (wrEn),
    .wrAddr (wrAddr),
    .wrData (wrData),
    .wrStrb (wrStrb),
    .wrHit  (isMapped(wrAddr)),
    .rdAddr (rdAddr),
    .rdData (rdData),
    .rdHit  (isMapped(rdAddr))
  );

  uep0_sync u_sync_wake
  (
    .mclk  (mclk),
    .rst_n (rst_n),
    .pinIn (wakeupPin),
    .level (wakeLevel)
  );

  uep0_sync u_sync_ring
  (
    .mclk  (mclk),
    .rst_n (rst_n),
    .pinIn (ringPin),
    .level (ringLevel)
  );

  // ***********************************************************************
  // read mux
  // ***********************************************************************
  always_comb
  begin
    rdData = 32'h0000_0000;
    case (rdAddr)
      ADR_CFG:
      begin
        rdData[CFG_BUFFER_MANAGER_ALLOW_BIT]  = s.cfgUbme;
        rdData[CFG_TOG_BIT]   = s.toggle;
        rdData[CFG_STALL_BIT] = s.cfgStall;
        rdData[CFG_IE_BIT]    = s.cfgIe;
      end
      ADR_BCNT:
      begin
        rdData[BCNT_NAK_BIT] = s.bcntNak;
        rdData[3:0]          = s.bcntCnt;
      end
      ADR_MSK:
      begin
        rdData[7:0] = s.msk;
      end
      ADR_STA:
      begin
        rdData[7:0] = s.sta;
      end
      ADR_FADR:
      begin
        rdData[6:0] = s.fadr;
      end
      default:
      begin
        rdData = 32'h0000_0000;
      end
    endcase
  end

  // stored address decides, so a new address is answered from the edge after its write
  assign forUs = tok.valid && (tok.addr == s.fadr) && (tok.ep == EP_ZERO);

  // ***********************************************************************
  // next state
  // ***********************************************************************
  always_comb
  begin
    next_s          = s;
    next_s.hs.valid = 1'b0;
    next_s.done     = 1'b0;
    evt             = 8'h00;

    // software writes land on the low byte only
    if (wrEn && wrStrb[0])
    begin
      case (wrAddr)
        ADR_CFG:
        begin
          next_s.cfgUbme  = wrData[CFG_BUFFER_MANAGER_ALLOW_BIT];
          next_s.cfgStall = wrData[CFG_STALL_BIT];
          next_s.cfgIe    = wrData[CFG_IE_BIT];
        end
        ADR_BCNT:
        begin
          next_s.bcntNak = wrData[BCNT_NAK_BIT];
          next_s.bcntCnt = clampCount(wrData[3:0]);
        end
        ADR_MSK:
        begin
          next_s.msk = wrData[7:0] & STA_IMPL_MASK;
        end
        ADR_STA:
        begin
          next_s.sta = s.sta & ~wrData[7:0];
        end
        ADR_FADR:
        begin
          next_s.fadr = wrData[6:0];
        end
        default:
        begin
          next_s.fadr = next_s.fadr;
        end
      endcase
    end

    // ***********************************************************************
    // bus events
    // ***********************************************************************
    next_s.wakePrev = wakeLevel;
    next_s.ringPrev = ringLevel;
    evt[STA_WAKE_BIT] = roseNow(wakeLevel, s.wakePrev);
    evt[STA_RING_BIT] = roseNow(ringLevel, s.ringPrev);
    evt[STA_RES_BIT]  = resumePulse;
    evt[STA_SUS_BIT]  = suspendPulse;
    evt[STA_RST_BIT]  = portResetPulse;

    // function reset returns the endpoint and address, never the status flags
    if (portResetPulse)
    begin
      next_s.cfgUbme  = CFG_BUFFER_MANAGER_ALLOW_RST;
      next_s.cfgStall = CFG_STALL_RST;
      next_s.cfgIe    = CFG_IE_RST;
      next_s.toggle   = CFG_TOG_RST;
      next_s.bcntNak  = BCNT_NAK_RST;
      next_s.bcntCnt  = BCNT_CNT_RST;
      next_s.fadr     = FADR_RST;
    end
    else if (forUs)
    begin
      // ***********************************************************************
      // endpoint-zero transactions
      // ***********************************************************************
      case (tok.kind)
        TOK_SETUP:
        begin
          evt[STA_SETUP_BIT]  = 1'b1;
          evt[STA_SETUP_OVERWRITE_FLAG_BIT]  = s.sta[STA_SETUP_BIT];
          // data stage after a setup always opens on DATA1
          next_s.toggle       = 1'b1;
          next_s.hs.valid     = 1'b1;
          next_s.hs.code      = HS_ACK;
        end
        TOK_OUT:
        begin
          next_s.hs.valid = 1'b1;
          if (s.sta[STA_SETUP_BIT])
          begin
            next_s.hs.code = HS_NAK;
          end
          else if (s.cfgStall)
          begin
            next_s.hs.code  = HS_STALL;
            next_s.cfgStall = 1'b0;
          end
          else if (!s.cfgUbme || s.bcntNak)
          begin
            next_s.hs.code = HS_NAK;
          end
          else if (tok.pid != s.toggle)
          begin
            // repeated packet: ack so the host moves on, keep the buffer
            next_s.hs.code = HS_ACK;
          end
          else
          begin
            next_s.hs.code  = HS_ACK;
            next_s.bcntCnt  = clampCount(tok.len);
            next_s.bcntNak  = 1'b1;
            next_s.toggle   = !s.toggle;
            next_s.done     = s.cfgIe;
          end
        end
        TOK_IN:
        begin
          // only the setup hold is ours; otherwise the input side answers
          if (s.sta[STA_SETUP_BIT])
          begin
            next_s.hs.valid = 1'b1;
            next_s.hs.code  = HS_NAK;
          end
        end
        default:
        begin
          next_s.hs.valid = 1'b0;
        end
      endcase
    end

    // a set in the clearing cycle wins
    next_s.sta   = (next_s.sta | evt) & STA_IMPL_MASK;
    // from the next state, so a mask write acts at the same edge
    next_s.irq   = |(next_s.sta & next_s.msk);
    next_s.allow = next_s.cfgUbme;
  end

  // ***********************************************************************
  // registers
  // ***********************************************************************
  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      s          <= '0;
      // buffer starts full: no OUT is taken until software rearms it
      s.bcntNak  <= BCNT_NAK_RST;
      s.bcntCnt  <= BCNT_CNT_RST;
      s.fadr     <= FADR_RST;
      s.sta      <= STA_RST;
      s.msk      <= MSK_RST;
      s.hs.code  <= HS_ACK;
    end
    else
    begin
      s <= next_s;
    end
  end

  // ***********************************************************************
  // outputs
  // ***********************************************************************
  // every output is a state flop, never next-state logic
  assign hs          = s.hs;
  assign bufMgrAllow = s.allow;
  assign ep0OutDone  = s.done;
  assign usbIrq      = s.irq;

endmodule : uep0_out_status

/* sim/uep0_out_status_asserts.sv */
// port-level checks for the endpoint-zero output and status block
`timescale 1ns/1ps
module uep0_out_status_asserts
  import uep0_pkg::*;
(
  input  wire logic     mclk,
  input  wire logic     rst_n,
  input  uep0_axil_req_t axiReq,
  input  uep0_tok_t     tok,
  input  uep0_hs_t      hs,
  input  wire logic     portResetPulse,
  input  wire logic     bufMgrAllow,
  input  wire logic     ep0OutDone,
  input  wire logic     usbIrq
);
  // ************************************
  // helper state
  // ************************************
  uep0_tok_t  prevTok;
  logic [1:0] ctlAge;
  // age saturates so a stale write never excuses a late change
  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
      ctlAge <= 2'h3;
    else if (axiReq.wvalid || portResetPulse)
      ctlAge <= 2'h0;
    else if (ctlAge != 2'h3)
      ctlAge <= ctlAge + 2'h1;
  end
  always_ff @(posedge mclk)
  begin
    prevTok <= tok;
  end
  // ************************************
  // properties
  // ************************************
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_n);
  sequence sOutTok;
    tok.valid && tok.kind == TOK_OUT;
  endsequence
  sequence sStallHs;
    hs.valid && hs.code == HS_STALL;
  endsequence
  a_done_is_ack: assert property (ep0OutDone |-> hs.valid && hs.code == HS_ACK)
    else $error("completion pulse without ack");
  a_done_from_out: assert property (ep0OutDone |-> prevTok.valid && prevTok.kind == TOK_OUT)
    else $error("completion pulse without out token");
  a_hs_from_tok: assert property (hs.valid |-> prevTok.valid && prevTok.ep == EP_ZERO)
    else $error("handshake without token");
  a_setup_acked: assert property (hs.valid && prevTok.kind == TOK_SETUP |-> hs.code == HS_ACK)
    else $error("setup not acked");
  a_in_naked: assert property (hs.valid && prevTok.kind == TOK_IN |-> hs.code == HS_NAK)
    else $error("in answered other than nak");
  a_stall_once: assert property (sStallHs ##0 sOutTok ##0 !portResetPulse |=> !sStallHs)
    else $error("stall answered twice");
  a_irq_falls_write: assert property ($fell(usbIrq) |-> ctlAge < 2'h3)
    else $error("interrupt dropped without a write");
  a_allow_cause: assert property ($changed(bufMgrAllow) |-> ctlAge < 2'h3)
    else $error("allow changed by itself");
  a_rst_keeps_irq: assert property (usbIrq && portResetPulse && !axiReq.wvalid |=> usbIrq)
    else $error("function reset cleared interrupt");
endmodule : uep0_out_status_asserts

bind uep0_out_status uep0_out_status_asserts u_chk (.mclk(mclk), .rst_n(rst_n), .axiReq(axiReq), .tok(tok),
  .hs(hs), .portResetPulse(portResetPulse), .bufMgrAllow(bufMgrAllow), .ep0OutDone(ep0OutDone), .usbIrq(usbIrq));

/* sim/uep0_usb_host.sv */
// usb host stand-in that turns bench commands into one-cycle token pulses
`timescale 1ns/1ps
module uep0_usb_host
  import uep0_pkg::*;
(
  input  wire logic mclk,
  input  wire logic rst_n,
  input  uep0_tok_t cmd,
  output uep0_tok_t tok
);
  // ************************************
  // token driver
  // ************************************
  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
      tok <= '0;
    else if (cmd.valid)
      tok <= cmd; // lengths kept 0..8, target address from the command
    else
      tok <= '{1'b0, tok.kind, ~tok.addr, ~tok.ep, ~tok.len, ~tok.pid}; // idle fields other than valid and kind invert each cycle, so they hold stale values on every second idle cycle
  end
endmodule : uep0_usb_host

/* sim/tb_top.sv */
// self-checking bench for the endpoint-zero output and status block
`timescale 1ns/1ps
module tb_top
  import uep0_pkg::*;
;
  typedef struct packed { logic [31:0] a; logic [7:0] d; logic [7:0] e; logic [1:0] r; } uep0_row_t;
  localparam logic [4:0] G_ACK = {1'b1, HS_ACK, 1'b0};
  localparam logic [4:0] G_DONE = {1'b1, HS_ACK, 1'b1};
  localparam logic [4:0] G_NAK = {1'b1, HS_NAK, 1'b0};
  logic           mclk = 1'b0;
  logic           rst_n = 1'b0;
  uep0_axil_req_t req = '0;
  uep0_axil_rsp_t rsp;
  uep0_tok_t      cmd = '0;
  uep0_tok_t      tok;
  uep0_hs_t       hs;
  logic           rstP = 1'b0;
  logic           susP = 1'b0;
  logic           resP = 1'b0;
  logic           wakePin = 1'b0;
  logic           ringPin = 1'b0;
  logic           allow;
  logic           done;
  logic           irq;
  int             miscompares = 0;
  int             checkCount = 0;
  logic [31:0]    v;
  logic [1:0]     r;
  uep0_row_t rows [8] = '{'{ADR_CFG, 8'hff, 8'h8c, RESP_OKAY}, '{ADR_CFG, 8'h84, 8'h84, RESP_OKAY},
    '{ADR_BCNT, 8'hff, 8'h88, RESP_OKAY}, '{ADR_BCNT, 8'h00, 8'h00, RESP_OKAY},
    '{ADR_FADR, 8'hff, 8'h7f, RESP_OKAY}, '{ADR_FADR, 8'h05, 8'h05, RESP_OKAY},
    '{ADR_MSK, 8'hff, 8'hef, RESP_OKAY}, '{32'h100, 8'hff, 8'h00, RESP_DECERR}};
  always #5 mclk = ~mclk;
  uep0_out_status dut (.mclk(mclk), .rst_n(rst_n), .axiReq(req), .axiRsp(rsp), .tok(tok), .hs(hs),
    .portResetPulse(rstP), .suspendPulse(susP), .resumePulse(resP), .wakeupPin(wakePin), .ringPin(ringPin),
    .bufMgrAllow(allow), .ep0OutDone(done), .usbIrq(irq));
  uep0_usb_host host (.mclk(mclk), .rst_n(rst_n), .cmd(cmd), .tok(tok));
  // ************************************
  // tasks
  // ************************************
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    checkCount++;
    if (g !== e)
    begin
      miscompares++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask : chk
  task automatic wr(input logic [31:0] a, input logic [31:0] d);
    req.awaddr <= a;
    req.wdata <= d;
    req.wstrb <= 4'hf;
    req.awvalid <= 1'b1;
    req.wvalid <= 1'b1;
    req.bready <= 1'b1;
    do
    begin
      @(posedge mclk);
      if (req.awvalid && rsp.awready)
        req.awvalid <= 1'b0;
      if (req.wvalid && rsp.wready)
        req.wvalid <= 1'b0;
    end
    while (!rsp.bvalid);
    r = rsp.bresp;
    // bready stays high: a following call must not drop and raise it in one step
  endtask : wr
  task automatic rd(input logic [31:0] a);
    req.araddr <= a;
    req.arvalid <= 1'b1;
    req.rready <= 1'b1;
    do
    begin
      @(posedge mclk);
      if (req.arvalid && rsp.arready)
        req.arvalid <= 1'b0;
    end
    while (!rsp.rvalid);
    v = rsp.rdata;
    r = rsp.rresp;
  endtask : rd
  task automatic rdc(input logic [31:0] a, input logic [31:0] e);
    rd(a);
    chk(v, e);
  endtask : rdc
  task automatic tk(input uep0_tok_kind_t k, input logic [6:0] a, input logic p, input logic [3:0] l,
                    input logic [4:0] e);
    cmd <= '{1'b1, k, a, EP_ZERO, l, p};
    @(posedge mclk);
    cmd.valid <= 1'b0;
    @(posedge mclk);
    #1;
    chk({27'h0, hs.valid, hs.valid ? hs.code : 3'h0, done}, {27'h0, e});
  endtask : tk
  task automatic finishTest;
    $display("comparisons %0d, mismatches %0d", checkCount, miscompares);
    if (miscompares == 0 && checkCount > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask : finishTest
  // ************************************
  // watchdog: run needs well under 2000 cycles
  // ************************************
  initial
  begin
    #100us;
    miscompares++;
    finishTest();
  end
  // ************************************
  // main sequence
  // ************************************
  initial
  begin
    repeat (6) @(posedge mclk);
    rst_n <= 1'b1;
    rdc(ADR_CFG, 32'h00);
    rdc(ADR_BCNT, 32'h80);
    rdc(ADR_FADR, 32'h00);
    rdc(ADR_STA, 32'h00);
    rdc(ADR_MSK, 32'h00);
    foreach (rows[i])
    begin
      wr(rows[i].a, {24'h0, rows[i].d});
      chk({30'h0, r}, {30'h0, rows[i].r});
      rdc(rows[i].a, {24'h0, rows[i].e});
      chk({30'h0, r}, {30'h0, rows[i].r});
    end
    tk(TOK_OUT, 7'h05, 1'b0, 4'h5, G_DONE);
    rdc(ADR_BCNT, 32'h85);
    rdc(ADR_CFG, 32'ha4);
    tk(TOK_OUT, 7'h05, 1'b1, 4'h3, G_NAK);
    rdc(ADR_BCNT, 32'h85);
    wr(ADR_BCNT, 32'h0);
    tk(TOK_OUT, 7'h06, 1'b1, 4'h8, 5'h00);
    tk(TOK_OUT, 7'h05, 1'b0, 4'h8, G_ACK);
    rdc(ADR_BCNT, 32'h00);
    wr(ADR_CFG, 32'h80);
    tk(TOK_OUT, 7'h05, 1'b1, 4'h8, G_ACK);
    rdc(ADR_BCNT, 32'h88);
    rdc(ADR_CFG, 32'h80);
    wr(ADR_CFG, 32'h04);
    wr(ADR_BCNT, 32'h0);
    tk(TOK_OUT, 7'h05, 1'b0, 4'h2, G_NAK);
    chk({31'h0, allow}, 32'h0);
    wr(ADR_CFG, 32'h8c);
    chk({31'h0, allow}, 32'h1);
    // two tokens back to back: only the first may see the stall
    cmd <= '{1'b1, TOK_OUT, 7'h05, EP_ZERO, 4'h4, 1'b0};
    @(posedge mclk);
    @(posedge mclk);
    cmd.valid <= 1'b0;
    #1;
    chk({28'h0, hs.valid, hs.code}, {28'h0, 1'b1, HS_STALL});
    @(posedge mclk);
    #1;
    chk({27'h0, hs.valid, hs.code, done}, {27'h0, G_DONE});
    rdc(ADR_CFG, 32'ha4);
    tk(TOK_SETUP, 7'h05, 1'b0, 4'h0, G_ACK);
    rdc(ADR_STA, 32'h04);
    wr(ADR_BCNT, 32'h0);
    tk(TOK_OUT, 7'h05, 1'b1, 4'h1, G_NAK);
    tk(TOK_IN, 7'h05, 1'b0, 4'h0, G_NAK);
    tk(TOK_SETUP, 7'h05, 1'b0, 4'h0, G_ACK);
    rdc(ADR_STA, 32'h05);
    chk({31'h0, irq}, 32'h1);
    wr(ADR_STA, 32'h04);
    rdc(ADR_STA, 32'h01);
    wr(ADR_STA, 32'h00);
    rdc(ADR_STA, 32'h01);
    wr(ADR_STA, 32'hff);
    chk({31'h0, irq}, 32'h0);
    tk(TOK_IN, 7'h05, 1'b0, 4'h0, 5'h00);
    susP <= 1'b1;
    resP <= 1'b1;
    @(posedge mclk);
    susP <= 1'b0;
    resP <= 1'b0;
    wakePin <= 1'b1;
    ringPin <= 1'b1;
    repeat (8) @(posedge mclk);
    rdc(ADR_STA, 32'h6a);
    wr(ADR_MSK, 32'h00);
    chk({31'h0, irq}, 32'h0);
    wr(ADR_MSK, 32'h20);
    chk({31'h0, irq}, 32'h1);
    rstP <= 1'b1;
    @(posedge mclk);
    rstP <= 1'b0;
    rdc(ADR_STA, 32'hea);
    rdc(ADR_FADR, 32'h00);
    rdc(ADR_MSK, 32'h20);
    rst_n <= 1'b0;
    repeat (3) @(posedge mclk);
    rst_n <= 1'b1;
    rdc(ADR_STA, 32'h00);
    finishTest();
  end
endmodule : tb_top
